// File: verilog/vipu_pkg.sv
package vipu_pkg;
  // Number of maskable request ranks, 0 is served first
  localparam int unsigned NUM_RANKS = 24;
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_REQ_FLAGS = 8'h00;
  localparam logic [7:0] OFS_MASK_FLAGS = 8'h04;
  localparam logic [7:0] OFS_PRIO_FLAGS = 8'h08;
  localparam logic [7:0] OFS_LV_MODE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_VECTOR = 8'h14;
  // Reset values: requests clear, all masked, all in the low group
  localparam logic [23:0] RST_REQ_FLAGS = 24'h00_0000;
  localparam logic [23:0] RST_MASK_FLAGS = 24'hFF_FFFF;
  localparam logic [23:0] RST_PRIO_FLAGS = 24'hFF_FFFF;
  localparam logic [7:0] RST_LV_MODE = 8'h00;
  // Field positions
  localparam int unsigned LV_ACTION_BIT = 1;
  localparam int unsigned ST_ISR_HIGH = 0;
  localparam int unsigned ST_ISR_LOW = 1;
  localparam int unsigned ST_BREAK_PEND = 2;
  localparam int unsigned ST_INT_REQ = 3;
  localparam int unsigned ST_CAUSE_LSB = 8;
  // Reset cause bit positions inside the cause field
  localparam int unsigned CAUSE_PIN = 0;
  localparam int unsigned CAUSE_POWER_ON = 1;
  localparam int unsigned CAUSE_LV = 2;
  localparam int unsigned CAUSE_WATCHDOG = 3;
  // Fixed ranks of the shared and special requests
  localparam logic [4:0] RANK_LV = 5'h00;
  localparam logic [4:0] RANK_SERIAL = 5'h0A;
  localparam logic [4:0] RANK_PIN_LAST = 5'h16;
  localparam logic [4:0] RANK_LAST = 5'h17;
  // Vector table addresses
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0004;
  localparam logic [15:0] VEC_LAST = 16'h0034;
  localparam logic [15:0] VEC_BREAK = 16'h003E;
endpackage

// File: verilog/vipu_top.sv
`timescale 1ns/1ns
// What this block does
// R01: Per-source priority flag selects high or low group
// R02: High request may interrupt a low service
// R03: Same group ties go to lowest rank
// R04: Any unmasked request raises standby release
// R05: Break vectors 003EH, ignores enable and priority
// R06: Eight external and sixteen internal maskable sources
// R07: Vectors from 0004H, two bytes per rank through rank 22, rank 23 at 0034H
// R08: Clocked serial and async transmit share rank 10
// R09: Two-wire and multiply/divide share rank 23
// R10: Four reset causes start at vector 0000H
// R11: Low-voltage mode bit 1 picks interrupt or reset
// R12: Pin edges at ranks 1-6 and 22
// R13: Twenty-five sources including the break
// R14: Acknowledge clears the source's request flag
// R15: Masked request kept but never presented
module vipu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_voltage_detect,
  input wire logic [6:0] pin_edge_irq,
  input wire logic [13:0] periph_irq,
  input wire logic clocked_serial_done_irq,
  input wire logic async_serial_tx_done_irq,
  input wire logic two_wire_done_irq,
  input wire logic muldiv_done_irq,
  input wire logic break_instruction,
  input wire logic reset_pin_cause,
  input wire logic power_on_clear,
  input wire logic watchdog_overflow_cause,
  input wire logic cpu_int_enable,
  input wire logic int_ack,
  input wire logic int_return,
  output logic int_req,
  output logic int_is_break,
  output logic [15:0] int_vector,
  output logic standby_release,
  output logic reset_req
);

  // Lowest set index of a request vector
  function automatic logic [4:0] first_set(input logic [23:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 23; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = i[4:0];
      end
    end
    return idx;
  endfunction

  // Vector address of a maskable rank
  function automatic logic [15:0] vec_of(input logic [4:0] rank);
    logic [15:0] v;
    v = vipu_pkg::VEC_BASE + {10'h000, rank, 1'b0}; // see R07
    if (rank == vipu_pkg::RANK_LAST)
    begin
      v = vipu_pkg::VEC_LAST; // see R09
    end
    return v;
  endfunction

  // Software visible state
  logic [23:0] req_flags_reg; // Pending request flags
  logic [23:0] mask_flags_reg; // 1 keeps a request away from the CPU
  logic [23:0] priority_group_flags_reg; // 1 puts the source in the low group
  logic [7:0] low_voltage_mode_reg; // Holds the detection action select
  logic [3:0] reset_cause_reg; // Sticky reset causes, write one to clear
  // Service state
  logic break_pend_reg; // Break waiting for its acknowledge
  logic isr_high_reg;
  logic isr_low_reg;
  logic int_req_reg;
  logic int_is_break_reg;
  logic int_low_reg; // Group of the presented source
  logic [4:0] int_src_reg; // Rank of the presented source
  logic [15:0] int_vector_reg;
  logic standby_release_reg;
  logic reset_req_reg;
  // APB answer flops
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Bus phase decode: one wait state, so every output comes from a flop
  wire apb_first = psel && penable && !pready_reg;
  wire apb_done = psel && penable && pready_reg;
  wire wr_en = apb_done && pwrite;
  wire hit_req = (paddr == vipu_pkg::OFS_REQ_FLAGS);
  wire hit_mask = (paddr == vipu_pkg::OFS_MASK_FLAGS);
  wire hit_prio = (paddr == vipu_pkg::OFS_PRIO_FLAGS);
  wire hit_lv = (paddr == vipu_pkg::OFS_LV_MODE);
  wire hit_stat = (paddr == vipu_pkg::OFS_STATUS);
  wire hit_vec = (paddr == vipu_pkg::OFS_VECTOR);
  wire hit_any = hit_req || hit_mask || hit_prio || hit_lv || hit_stat || hit_vec;

  // Low-voltage detection goes one way or the other, never both
  wire lv_as_reset = low_voltage_mode_reg[vipu_pkg::LV_ACTION_BIT];
  wire low_voltage_irq = low_voltage_detect && !lv_as_reset; // see R11

  // Source to rank map: 8 external (7 pins + key), 16 internal
  wire [23:0] raise; // see R06
  assign raise[0] = low_voltage_irq;
  assign raise[6:1] = pin_edge_irq[5:0]; // see R12
  assign raise[9:7] = periph_irq[2:0];
  assign raise[10] = clocked_serial_done_irq || async_serial_tx_done_irq; // see R08
  assign raise[21:11] = periph_irq[13:3];
  assign raise[22] = pin_edge_irq[6]; // see R12
  assign raise[23] = two_wire_done_irq || muldiv_done_irq; // see R09

  // Acknowledge and return decode
  wire ack_take = int_ack && int_req_reg;
  wire ack_break = ack_take && int_is_break_reg;
  wire ack_mask = ack_take && !int_is_break_reg;
  wire [23:0] ack_clr = ack_mask ? (24'h00_0001 << int_src_reg) : 24'h00_0000;

  // Next flag state: software write, then acknowledge clear, new event wins
  wire [23:0] flags_base = (wr_en && hit_req) ? pwdata[23:0] : req_flags_reg;
  wire [23:0] flags_next = (flags_base & ~ack_clr) | raise; // see R14
  wire [23:0] mask_next = (wr_en && hit_mask) ? pwdata[23:0] : mask_flags_reg;
  wire [23:0] prio_next = (wr_en && hit_prio) ? pwdata[23:0] : priority_group_flags_reg;
  wire break_next = (break_pend_reg && !ack_break) || break_instruction; // see R05 R13

  // Returns unwind the newest level first; an acknowledge opens a level, except a break acknowledge
  wire ret_high = int_return && isr_high_reg;
  wire ret_low = int_return && !isr_high_reg;
  wire isr_high_next = (isr_high_reg && !ret_high) || (ack_mask && !int_low_reg);
  wire isr_low_next = (isr_low_reg && !ret_low) || (ack_mask && int_low_reg);

  // Candidates from next state, so presentation is never a cycle stale
  wire [23:0] cand = flags_next & ~mask_next; // see R15
  wire [23:0] cand_high = cand & ~prio_next; // see R01
  wire [23:0] cand_low = cand & prio_next; // see R01
  wire pick_high = cpu_int_enable && (|cand_high) && !isr_high_next; // see R02
  wire pick_low = cpu_int_enable && (|cand_low) && !isr_high_next && !isr_low_next;
  wire [4:0] rank_high = first_set(cand_high); // see R03
  wire [4:0] rank_low = first_set(cand_low); // see R03
  wire [4:0] rank_sel = pick_high ? rank_high : rank_low;

  // Reset causes, all of which restart at the reset vector
  wire [3:0] cause_now = {watchdog_overflow_cause, low_voltage_detect && lv_as_reset,
                          power_on_clear, reset_pin_cause}; // see R10
  wire [3:0] cause_clr = (wr_en && hit_stat) ? pwdata[11:8] : 4'h0;

  // Read mux
  wire [31:0] status_word = {20'h0_0000, reset_cause_reg, 4'h0, int_req_reg,
                             break_pend_reg, isr_low_reg, isr_high_reg};
  wire [31:0] rd_mux =
    hit_req ? {8'h00, req_flags_reg} :
    hit_mask ? {8'h00, mask_flags_reg} :
    hit_prio ? {8'h00, priority_group_flags_reg} :
    hit_lv ? {24'h00_0000, low_voltage_mode_reg} :
    hit_stat ? status_word :
    hit_vec ? {16'h0000, int_vector_reg} : 32'h0000_0000;

  // APB answer: data and error are loaded in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= apb_first;
      prdata_reg <= apb_first ? rd_mux : 32'h0000_0000;
      pslverr_reg <= apb_first && !hit_any;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_flags_reg <= vipu_pkg::RST_MASK_FLAGS;
      priority_group_flags_reg <= vipu_pkg::RST_PRIO_FLAGS;
      low_voltage_mode_reg <= vipu_pkg::RST_LV_MODE;
    end
    else
    begin
      mask_flags_reg <= mask_next;
      priority_group_flags_reg <= prio_next;
      if (wr_en && hit_lv)
      begin
        low_voltage_mode_reg <= pwdata[7:0];
      end
    end
  end

  // Request flags, break latch and in-service levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_flags_reg <= vipu_pkg::RST_REQ_FLAGS;
      break_pend_reg <= 1'b0;
      isr_high_reg <= 1'b0;
      isr_low_reg <= 1'b0;
    end
    else
    begin
      req_flags_reg <= flags_next; // see R14
      break_pend_reg <= break_next; // see R05
      isr_high_reg <= isr_high_next; // see R02
      isr_low_reg <= isr_low_next;
    end
  end

  // Presentation to the CPU; a break outranks all and ignores enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_req_reg <= 1'b0;
      int_is_break_reg <= 1'b0;
      int_low_reg <= 1'b0;
      int_src_reg <= 5'h00;
      int_vector_reg <= vipu_pkg::VEC_RESET;
    end
    else if (break_next)
    begin
      int_req_reg <= 1'b1; // see R05
      int_is_break_reg <= 1'b1;
      int_low_reg <= 1'b0;
      int_src_reg <= 5'h00;
      int_vector_reg <= vipu_pkg::VEC_BREAK; // see R05
    end
    else
    begin
      int_req_reg <= pick_high || pick_low;
      int_is_break_reg <= 1'b0;
      int_low_reg <= !pick_high;
      int_src_reg <= rank_sel;
      // Idle vector reads as the reset vector
      int_vector_reg <= (pick_high || pick_low) ? vec_of(rank_sel) : vipu_pkg::VEC_RESET;
    end
  end

  // Wake and reset signalling; wake ignores the global enable on purpose
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      standby_release_reg <= 1'b0;
      reset_req_reg <= 1'b0;
      reset_cause_reg <= 4'h0;
    end
    else
    begin
      standby_release_reg <= |cand; // see R04
      reset_req_reg <= |cause_now; // see R10
      reset_cause_reg <= (reset_cause_reg & ~cause_clr) | cause_now;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign int_req = int_req_reg;
  assign int_is_break = int_is_break_reg;
  assign int_vector = int_vector_reg;
  assign standby_release = standby_release_reg;
  assign reset_req = reset_req_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Helper: lower ranks of the presented one, same group, still eligible
  wire [23:0] lower_mask = (24'h00_0001 << int_src_reg) - 24'h00_0001;
  wire [23:0] same_grp = int_low_reg ? priority_group_flags_reg : ~priority_group_flags_reg;
  wire [23:0] live = req_flags_reg & ~mask_flags_reg;

  sequence s_ack_taken;
    int_ack && int_req_reg && !int_is_break_reg;
  endsequence

  sequence s_no_refire;
    !raise[int_src_reg] && !(wr_en && hit_req);
  endsequence

  a_break_vector_fixed: assert property ( // see R05
    break_pend_reg |-> int_req_reg && int_is_break_reg && int_vector_reg == vipu_pkg::VEC_BREAK)
    else $error("break pending but not presented at its vector");
  a_vector_rank_map: assert property ( // see R07
    int_req_reg && !int_is_break_reg |-> int_vector_reg == vec_of(int_src_reg))
    else $error("presented vector does not match rank");
  a_ack_clears_flag: assert property ( // see R14
    (s_ack_taken and s_no_refire) |=> !req_flags_reg[$past(int_src_reg)])
    else $error("acknowledged request flag not cleared");
  a_mask_holds_off: assert property ( // see R15
    int_req_reg && !int_is_break_reg |->
      !mask_flags_reg[int_src_reg] && req_flags_reg[int_src_reg])
    else $error("masked or absent request presented");
  a_nest_group_rule: assert property ( // see R02
    int_req_reg && !int_is_break_reg |-> !isr_high_reg && !(int_low_reg && isr_low_reg))
    else $error("request presented against in-service level");
  a_rank_tie_order: assert property ( // see R03
    int_req_reg && !int_is_break_reg |-> (live & same_grp & lower_mask) == 24'h00_0000)
    else $error("a lower rank of the same group was passed over");
  a_group_high_first: assert property ( // see R01
    int_req_reg && !int_is_break_reg && int_low_reg |->
      (live & ~priority_group_flags_reg) == 24'h00_0000)
    else $error("low group presented while high group request waits");
  a_standby_wake: assert property ( // see R04
    (|live) |-> standby_release_reg)
    else $error("pending unmasked request without standby release");
  // In reset mode a detection must log a reset cause and leave the rank 0 flag alone
  a_lv_mode_split: assert property ( // see R11
    low_voltage_detect && lv_as_reset && !req_flags_reg[vipu_pkg::RANK_LV]
      && !(wr_en && hit_req) |=> reset_req_reg && reset_cause_reg[vipu_pkg::CAUSE_LV]
      && !req_flags_reg[vipu_pkg::RANK_LV])
    else $error("low-voltage reset mode raised no reset or an interrupt");
  a_shared_serial: assert property ( // see R08
    async_serial_tx_done_irq || clocked_serial_done_irq |=> req_flags_reg[vipu_pkg::RANK_SERIAL])
    else $error("shared serial request not flagged at rank 10");
  a_shared_last: assert property ( // see R09
    two_wire_done_irq || muldiv_done_irq |=> req_flags_reg[vipu_pkg::RANK_LAST])
    else $error("shared last request not flagged at rank 23");
  a_pin_rank_22: assert property ( // see R12
    pin_edge_irq[6] |=> req_flags_reg[vipu_pkg::RANK_PIN_LAST])
    else $error("seventh pin edge not flagged at rank 22");

endmodule

// File: dv/vipu_cpu_model.sv
`timescale 1ns/1ns
// CPU core model: takes presented requests and returns from service later
module vipu_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic int_req,
  input wire logic int_is_break,
  input wire logic [1:0] ack_dly,
  input wire logic hold_ret,
  output logic int_ack,
  output logic int_return
);
  logic [1:0] wait_reg; // Cycles spent before acknowledging
  logic [4:0] depth_reg; // Services entered and not yet left
  // One acknowledge per presentation; a held return models a long handler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_ack <= 1'b0;
      int_return <= 1'b0;
      wait_reg <= 2'h0;
      depth_reg <= 5'h00;
    end
    else
    begin
      int_ack <= 1'b0;
      int_return <= 1'b0;
      // Slow or prompt acknowledge, never twice in a row
      if (int_req && !int_ack && wait_reg >= ack_dly)
      begin
        int_ack <= 1'b1;
        wait_reg <= 2'h0;
        // The break enters no service level, so no return follows it
        if (!int_is_break)
          depth_reg <= depth_reg + 5'h01;
      end
      else if (int_req && !int_ack)
        wait_reg <= wait_reg + 2'h1;
      else if (depth_reg != 5'h00 && !hold_ret && !int_return && !int_ack)
      begin
        int_return <= 1'b1;
        depth_reg <= depth_reg - 5'h01;
      end
    end
  end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the vectored interrupt prioritiser
module tb_top;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr; // Byte address
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, int_req, int_is_break, standby_release, reset_req;
  logic [15:0] int_vector; // Presented vector
  logic [23:0] rk; // One pulse bit per rank
  logic [23:0] m; // Random set of ranks
  logic alt; // Picks which source of a shared rank fires
  logic [2:0] rc; // Reset causes: pin, power-on, watchdog
  logic break_pulse, ien, ack, ret, hold;
  logic [1:0] dly; // Acknowledge delay of the CPU model
  int miscompares, samples_checked, seed, n;
  logic [16:0] exp_vec[$]; // Break flag and vector per acknowledge
  logic [32:0] exp_rd[$]; // Error flag and data per read
  // Rank pulses fan out to the real source inputs
  wire low_voltage_detect = rk[0];
  wire [6:0] pin_edge_irq = {rk[22], rk[6:1]};
  wire [13:0] periph_irq = {rk[21:11], rk[9:7]};
  wire clocked_serial_done_irq = rk[10] & ~alt;
  wire async_serial_tx_done_irq = rk[10] & alt;
  wire two_wire_done_irq = rk[23] & ~alt;
  wire muldiv_done_irq = rk[23] & alt;

  vipu_top i_vipu_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .low_voltage_detect, .pin_edge_irq, .periph_irq,
    .clocked_serial_done_irq, .async_serial_tx_done_irq, .two_wire_done_irq,
    .muldiv_done_irq, .break_instruction(break_pulse), .reset_pin_cause(rc[0]),
    .power_on_clear(rc[1]), .watchdog_overflow_cause(rc[2]), .cpu_int_enable(ien),
    .int_ack(ack), .int_return(ret), .int_req, .int_is_break, .int_vector,
    .standby_release, .reset_req);
  vipu_cpu_model i_vipu_cpu_model (.pclk, .presetn, .int_req, .int_is_break,
    .ack_dly(dly), .hold_ret(hold), .int_ack(ack), .int_return(ret));

  // Clock, 4 ns period
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task check(input string nm, input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Expected vector: two bytes per rank, the last rank skips a slot
  function automatic logic [16:0] vx(input int r);
    if (r == 23)
      return {1'b0, vipu_pkg::VEC_LAST};
    return {1'b0, vipu_pkg::VEC_BASE + 16'(2 * r)};
  endfunction

  // APB master: setup, then access held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Fire ranks and the break for one cycle, then let the event land
  task fire(input logic [23:0] s, input logic b);
    @(posedge pclk);
    rk <= s;
    break_pulse <= b;
    @(posedge pclk);
    rk <= 24'h00_0000;
    break_pulse <= 1'b0;
    #1;
  endtask

  // Bounded wait until every expected acknowledge has been seen
  task drain;
    n = 0;
    while (exp_vec.size() != 0 && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
    check("pending", 33'(exp_vec.size()), 33'h0_0000_0000);
  endtask

  // Watcher: each acknowledge and each read answer takes the oldest note
  always @(posedge pclk)
  begin
    if (ack === 1'b1 && int_req === 1'b1)
    begin
      // An unplanned acknowledge meets a note that can never match
      if (exp_vec.size() == 0)
        exp_vec.push_back(17'h1_FFFF);
      check("vector", {int_is_break, int_vector}, exp_vec.pop_front());
    end
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("read", {pslverr, prdata}, exp_rd.pop_front());
  end

  initial
  begin
    seed = 32'h9a44a5ff;
    {presetn, psel, penable, pwrite, alt, break_pulse, hold, rc, dly} = '0;
    {paddr, pwdata, rk, miscompares, samples_checked} = '0;
    ien = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped offset
    rd(vipu_pkg::OFS_REQ_FLAGS, 33'h0_0000_0000);
    rd(vipu_pkg::OFS_MASK_FLAGS, 33'h0_00FF_FFFF);
    rd(vipu_pkg::OFS_PRIO_FLAGS, 33'h0_00FF_FFFF);
    rd(vipu_pkg::OFS_LV_MODE, 33'h0_0000_0000);
    rd(vipu_pkg::OFS_STATUS, 33'h0_0000_0000);
    rd(vipu_pkg::OFS_VECTOR, 33'h0_0000_0000);
    rd(8'h18, 33'h1_0000_0000);
    // Every rank alone, all unmasked in the high group
    apb(1'b1, vipu_pkg::OFS_MASK_FLAGS, 32'h0000_0000);
    apb(1'b1, vipu_pkg::OFS_PRIO_FLAGS, 32'h0000_0000);
    for (int r = 0; r < 24; r++)
    begin
      dly <= 2'($random(seed));
      alt <= 1'($random(seed));
      exp_vec.push_back(vx(r));
      fire(24'h00_0001 << r, 1'b0);
      check("wake", 33'(standby_release), 33'h0_0000_0001);
      drain;
    end
    // Simultaneous requests in one group go by rank
    repeat (4)
    begin
      // Both sources of each shared rank get their turn
      alt <= ~alt;
      m = 24'($random(seed)) | 24'h80_0400;
      for (int r = 0; r < 24; r++)
        if (m[r])
          exp_vec.push_back(vx(r));
      fire(m, 1'b0);
      drain;
    end
    // High group wins over a better ranked low one
    apb(1'b1, vipu_pkg::OFS_PRIO_FLAGS, 32'h007F_FFFF);
    exp_vec.push_back(vx(23));
    exp_vec.push_back(vx(0));
    fire(24'h80_0001, 1'b0);
    drain;
    // A high request nests on a low service, a low one must wait
    apb(1'b1, vipu_pkg::OFS_PRIO_FLAGS, 32'h00FF_FDFF);
    hold <= 1'b1;
    exp_vec.push_back(vx(5));
    fire(24'h00_0020, 1'b0);
    drain;
    fire(24'h00_0004, 1'b0);
    repeat (3) @(posedge pclk);
    check("nest_low", 33'(int_req), 33'h0_0000_0000);
    exp_vec.push_back(vx(9));
    fire(24'h00_0200, 1'b0);
    drain;
    exp_vec.push_back(vx(2));
    hold <= 1'b0;
    drain;
    // Masked request keeps its flag but is not presented
    apb(1'b1, vipu_pkg::OFS_MASK_FLAGS, 32'h0000_0008);
    fire(24'h00_0008, 1'b0);
    repeat (3) @(posedge pclk);
    check("masked", {int_req, standby_release}, 33'h0_0000_0000);
    rd(vipu_pkg::OFS_REQ_FLAGS, 33'h0_0000_0008);
    exp_vec.push_back(vx(3));
    apb(1'b1, vipu_pkg::OFS_MASK_FLAGS, 32'h0000_0000);
    drain;
    rd(vipu_pkg::OFS_REQ_FLAGS, 33'h0_0000_0000);
    // Break is taken with interrupts disabled; a request still wakes
    ien <= 1'b0;
    exp_vec.push_back({1'b1, vipu_pkg::VEC_BREAK});
    fire(24'h00_0000, 1'b1);
    drain;
    fire(24'h00_0002, 1'b0);
    repeat (3) @(posedge pclk);
    check("off_wake", {int_req, standby_release}, 33'h0_0000_0001);
    apb(1'b1, vipu_pkg::OFS_REQ_FLAGS, 32'h0000_0000);
    ien <= 1'b1;
    // Low voltage as a reset, then the other reset causes
    apb(1'b1, vipu_pkg::OFS_LV_MODE, 32'h0000_0002);
    fire(24'h00_0001, 1'b0);
    check("lv_reset", {reset_req, standby_release}, 33'h0_0000_0002);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      rc <= 3'b001 << i;
      @(posedge pclk);
      rc <= 3'b000;
      #1;
      check("reset", {reset_req, int_vector}, {16'h0001, vipu_pkg::VEC_RESET});
    end
    rd(vipu_pkg::OFS_STATUS, 33'h0_0000_0F00);
    // Causes are write one to clear
    apb(1'b1, vipu_pkg::OFS_STATUS, 32'h0000_0F00);
    rd(vipu_pkg::OFS_STATUS, 33'h0_0000_0000);
    give_verdict;
  end

  // Watchdog against a hang
  initial
  begin
    #80000;
    miscompares++;
    give_verdict;
  end
endmodule
